/* File: rtl/indicator_function_regs.sv */
// indicator override and upper function control bits
// assumes register port on ref_clk_i, strap and pins synchronised here
//
// Operation
// - Override register bits 15:6 ignore writes and always read zero.
// - With bit 5 set the speed output carries stored bit 2, else normal.
// - With bit 4 set the link output carries stored bit 1, else normal.
// - With bit 3 set the activity output carries stored bit 0, else normal.
// - Reading the override register returns stored settings, not pins.
// - Crossover enable resets from a strap and stays writable.
// - Force crossover swaps transmit and receive twisted pairs.
// - Pause receive is resolved from local and partner pause bits.
// - Pause transmit is resolved from local and partner pause bits.
// - Pause indications assert only for a full duplex negotiated result.
// - Writing one to the error inject bit gives one error, then clears.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module indicator_function_regs
	import led_ctrl_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire reg_req_t req_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic crossover_strap_i,
	input wire indicator_t normal_indicator_i,
	output indicator_t indicator_o,
	input wire logic an_complete_i,
	input wire logic an_full_duplex_i,
	input wire logic [DATA_W-1:0] local_advertisement_i,
	input wire logic [DATA_W-1:0] partner_ability_i,
	output logic auto_crossover_en_o,
	output logic force_crossover_o,
	output logic tx_on_rx_twisted_pair_o,
	output logic pause_rx_o,
	output logic pause_tx_o,
	output logic self_test_error_inject_o
);

	localparam int IND_N = 3;
	localparam int OVR_W = 2 * IND_N;

	// pin-side inputs pass two flops
	logic [1:0] strap_sync_r;
	logic [1:0] an_done_sync_r;
	logic [1:0] an_fd_sync_r;
	logic strap_taken_r;

	logic [OVR_W-1:0] override_r;
	logic auto_crossover_en_r;
	logic force_crossover_r;
	logic error_inject_r;
	logic pause_rx_r;
	logic pause_tx_r;
	logic [DATA_W-1:0] rdata_r;

	wire logic hit_override = req_i.addr == OFS_INDICATOR_OVERRIDE;
	wire logic hit_control = req_i.addr == OFS_PHY_FUNCTION_CONTROL;
	wire logic wr_override = req_i.wr && hit_override;
	wire logic wr_control = req_i.wr && hit_control;

	wire logic loc_pause = local_advertisement_i[BIT_ADV_PAUSE];
	wire logic loc_asym = local_advertisement_i[BIT_ADV_ASYM];
	wire logic lp_pause = partner_ability_i[BIT_ADV_PAUSE];
	wire logic lp_asym = partner_ability_i[BIT_ADV_ASYM];
	// standard pause resolution
	wire logic res_both = loc_pause && lp_pause;
	wire logic res_rx_only = loc_pause && loc_asym && !lp_pause && lp_asym;
	wire logic res_tx_only = !loc_pause && loc_asym && lp_pause && lp_asym;
	wire logic fd_done = an_done_sync_r[1] && an_fd_sync_r[1];
	wire logic pause_rx_nxt = fd_done && (res_both || res_rx_only);
	wire logic pause_tx_nxt = fd_done && (res_both || res_tx_only);

	wire logic [DATA_W-1:0] override_rd = {{(DATA_W-OVR_W){1'b0}},
		override_r};
	wire logic [DATA_W-1:0] control_rd = {auto_crossover_en_r,
		force_crossover_r, pause_rx_r, pause_tx_r, error_inject_r,
		{(BIT_ERR_INJECT){1'b0}}};
	wire logic [DATA_W-1:0] rdata_nxt = !req_i.rd ? '0 :
		hit_override ? override_rd :
		hit_control ? control_rd : '0;

	// per indicator enable, value and normal level
	wire logic [IND_N-1:0] ind_norm = normal_indicator_i;
	wire logic [IND_N-1:0] ind_en = override_r[OVR_W-1:IND_N];
	wire logic [IND_N-1:0] ind_val = override_r[IND_N-1:0];
	logic [IND_N-1:0] ind_mux;

	// field layout must fit the data word
	if (BIT_AUTO_XOVER_EN != DATA_W - 1 || OVR_W != BIT_SPEED_OVR_EN + 1)
	begin : gen_layout_check
		$error("register field layout does not fit the data word");
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			an_done_sync_r <= 2'h0;
			an_fd_sync_r <= 2'h0;
		end
		else
		begin
			an_done_sync_r <= {an_done_sync_r[0], an_complete_i};
			an_fd_sync_r <= {an_fd_sync_r[0], an_full_duplex_i};
		end
	end

	// strap sync has no reset so the level is ready at release
	always_ff @(posedge ref_clk_i)
	begin
		strap_sync_r <= {strap_sync_r[0], crossover_strap_i};
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			override_r <= OVERRIDE_RESET;
			rdata_r <= '0;
		end
		else
		begin
			if (wr_override)
				override_r <= req_i.wdata[OVR_W-1:0];
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			strap_taken_r <= 1'b0;
			auto_crossover_en_r <= 1'b0;
		end
		else if (wr_control)
		begin
			strap_taken_r <= 1'b1;
			auto_crossover_en_r <= req_i.wdata[BIT_AUTO_XOVER_EN];
		end
		else if (!strap_taken_r)
		begin
			strap_taken_r <= 1'b1;
			auto_crossover_en_r <= strap_sync_r[1];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			force_crossover_r <= 1'b0;
			error_inject_r <= 1'b0;
			pause_rx_r <= 1'b0;
			pause_tx_r <= 1'b0;
		end
		else
		begin
			if (wr_control)
				force_crossover_r <= req_i.wdata[BIT_FORCE_XOVER];
			error_inject_r <= wr_control && req_i.wdata[BIT_ERR_INJECT];
			pause_rx_r <= pause_rx_nxt;
			pause_tx_r <= pause_tx_nxt;
		end
	end

	for (genvar g = 0; g < IND_N; g++)
	begin : gen_ind
		assign ind_mux[g] = ind_en[g] ? ind_val[g] : ind_norm[g];
	end
	assign indicator_o = ind_mux;

	assign rdata_o = rdata_r;
	// software keeps this off without autonegotiation
	assign auto_crossover_en_o = auto_crossover_en_r;
	assign force_crossover_o = force_crossover_r;
	assign tx_on_rx_twisted_pair_o = force_crossover_r;
	assign pause_rx_o = pause_rx_r;
	assign pause_tx_o = pause_tx_r;
	assign self_test_error_inject_o = error_inject_r;

	chk_override_upper_zero: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && hit_override |=> rdata_o[DATA_W-1:OVR_W] == '0)
		else $error("override upper bits not zero");

	chk_unmapped_read: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && !hit_override && !hit_control |=> rdata_o == '0)
		else $error("unmapped read not zero");

	chk_speed_override: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_override && req_i.wdata[BIT_SPEED_OVR_EN] |=>
		indicator_o.speed == $past(req_i.wdata[BIT_SPEED_VAL]))
		else $error("speed override not applied");

	chk_speed_normal: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!override_r[BIT_SPEED_OVR_EN] |->
		indicator_o.speed == normal_indicator_i.speed)
		else $error("speed not normal");

	chk_link_override: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_override && req_i.wdata[BIT_LINK_OVR_EN] |=>
		indicator_o.link == $past(req_i.wdata[BIT_LINK_VAL]))
		else $error("link override not applied");

	chk_link_normal: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!override_r[BIT_LINK_OVR_EN] |->
		indicator_o.link == normal_indicator_i.link)
		else $error("link not normal");

	chk_act_override: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_override && req_i.wdata[BIT_ACT_OVR_EN] |=>
		indicator_o.activity == $past(req_i.wdata[BIT_ACT_VAL]))
		else $error("activity override not applied");

	chk_act_normal: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!override_r[BIT_ACT_OVR_EN] |-> indicator_o.activity ==
		normal_indicator_i.activity)
		else $error("activity not normal");

	chk_override_readback: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_override ##1 (req_i.rd && hit_override && !req_i.wr) |=>
		rdata_o[OVR_W-1:0] == $past(req_i.wdata[OVR_W-1:0], 2))
		else $error("override readback wrong");

	// read shows stored bits not pins
	chk_read_ignores_pins: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && hit_override |=>
		rdata_o[OVR_W-1:0] == $past(override_r))
		else $error("override read not from stored bits");

	chk_override_hold: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!wr_override |=> $stable(override_r))
		else $error("override changed without write");

	// read data only after a read
	chk_rdata_idle: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!req_i.rd |=> rdata_o == '0)
		else $error("read data without read");

	chk_strap_load: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!strap_taken_r && !wr_control |=>
		auto_crossover_en_o == $past(strap_sync_r[1]))
		else $error("strap not loaded");

	chk_xover_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_control |=>
		auto_crossover_en_o == $past(req_i.wdata[BIT_AUTO_XOVER_EN]))
		else $error("crossover enable not stored");

	chk_xover_hold: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		strap_taken_r && !wr_control |=> $stable(auto_crossover_en_o))
		else $error("crossover enable changed without write");

	chk_force_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_control |=>
		force_crossover_o == $past(req_i.wdata[BIT_FORCE_XOVER]))
		else $error("force crossover not stored");

	chk_force_hold: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!wr_control |=> $stable(force_crossover_o))
		else $error("force crossover changed without write");

	chk_pair_swap: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		tx_on_rx_twisted_pair_o == force_crossover_o)
		else $error("pair swap differs from force");

	chk_pause_both: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		fd_done && loc_pause && lp_pause |=> pause_rx_o && pause_tx_o)
		else $error("symmetric pause not resolved");

	chk_pause_rx_only: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		fd_done && loc_pause && loc_asym && !lp_pause && lp_asym |=>
		pause_rx_o && !pause_tx_o)
		else $error("receive only pause not resolved");

	chk_pause_tx_only: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		fd_done && !loc_pause && loc_asym && lp_pause && lp_asym |=>
		!pause_rx_o && pause_tx_o)
		else $error("transmit only pause not resolved");

	chk_pause_none: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!loc_pause && !lp_pause |=> !pause_rx_o && !pause_tx_o)
		else $error("pause without advertisement");

	chk_pause_read: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && hit_control |=>
		rdata_o[BIT_PAUSE_RX] == $past(pause_rx_o) &&
		rdata_o[BIT_PAUSE_TX] == $past(pause_tx_o))
		else $error("pause fields read wrong");

	chk_pause_half: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!an_fd_sync_r[1] |=> !pause_rx_o && !pause_tx_o)
		else $error("pause asserted in half duplex");

	chk_pause_gate: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!fd_done |=> !pause_rx_o && !pause_tx_o)
		else $error("pause asserted without full duplex");

	chk_inject_pulse: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_control && req_i.wdata[BIT_ERR_INJECT] |=>
		self_test_error_inject_o
		##1 (!self_test_error_inject_o || $past(wr_control, 1)))
		else $error("inject not single");

	chk_inject_idle: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!(wr_control && req_i.wdata[BIT_ERR_INJECT]) |=>
		!self_test_error_inject_o)
		else $error("inject without write");

	chk_inject_read: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && hit_control |=>
		rdata_o[BIT_ERR_INJECT] == $past(self_test_error_inject_o))
		else $error("inject bit read wrong");
endmodule

/* File: rtl/led_ctrl_pkg.sv */
// package for indicator override and function control registers
// assumes one register port on the device clock
package led_ctrl_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] OFS_INDICATOR_OVERRIDE = 5'h18;
	localparam logic [4:0] OFS_PHY_FUNCTION_CONTROL = 5'h19;
	// indicator override fields
	localparam int BIT_SPEED_OVR_EN = 5;
	localparam int BIT_LINK_OVR_EN = 4;
	localparam int BIT_ACT_OVR_EN = 3;
	localparam int BIT_SPEED_VAL = 2;
	localparam int BIT_LINK_VAL = 1;
	localparam int BIT_ACT_VAL = 0;
	localparam logic [5:0] OVERRIDE_RESET = 6'h00;
	// function control fields
	localparam int BIT_AUTO_XOVER_EN = 15;
	localparam int BIT_FORCE_XOVER = 14;
	localparam int BIT_PAUSE_RX = 13;
	localparam int BIT_PAUSE_TX = 12;
	localparam int BIT_ERR_INJECT = 11;
	// pause advertisement bits
	localparam int BIT_ADV_PAUSE = 10;
	localparam int BIT_ADV_ASYM = 11;

	typedef struct packed {
		logic speed;
		logic link;
		logic activity;
	} indicator_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

/* File: test/indicator_function_regs_bench.sv */
// bench for indicator override and function control registers
// assumes read data one cycle after the strobe and fixed pause latency
`timescale 1ns/1ps
module indicator_function_regs_bench;
	import led_ctrl_pkg::*;
	typedef struct packed {
		logic [15:0] w;
		indicator_t n;
		logic [15:0] r;
		indicator_t o;
	} row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b1;
	logic anc = 1'b0;
	logic afd = 1'b1;
	logic [15:0] ladv = 16'h0C00;
	logic [15:0] padv = 16'h0C00;
	reg_req_t req = '0;
	indicator_t norm = '0;
	indicator_t ind;
	logic [15:0] rdata, r;
	logic en, frc, swp, prx, ptx, inj;
	logic [3:0] c;
	logic erx, etx;
	int errors = 0;
	int total_checks = 0;
	row_t rows [6] = '{'{16'hFFFF, 3'b000, 16'h003F, 3'b111},
		'{16'h0038, 3'b111, 16'h0038, 3'b000},
		'{16'h0024, 3'b000, 16'h0024, 3'b100},
		'{16'h0012, 3'b100, 16'h0012, 3'b110},
		'{16'h0009, 3'b010, 16'h0009, 3'b011},
		'{16'h0007, 3'b101, 16'h0007, 3'b101}};

	indicator_function_regs DUT (.ref_clk_i(clk), .rst_n_i(rst_n),
		.req_i(req), .rdata_o(rdata), .crossover_strap_i(strap),
		.normal_indicator_i(norm), .indicator_o(ind),
		.an_complete_i(anc), .an_full_duplex_i(afd),
		.local_advertisement_i(ladv), .partner_ability_i(padv),
		.auto_crossover_en_o(en), .force_crossover_o(frc),
		.tx_on_rx_twisted_pair_o(swp), .pause_rx_o(prx),
		.pause_tx_o(ptx), .self_test_error_inject_o(inj));

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		#1;
	endtask

	task automatic wrrd(input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		q = rdata;
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		q = rdata;
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_INDICATOR_OVERRIDE, r);
		check(r, 16'h0000);
		rd(OFS_PHY_FUNCTION_CONTROL, r);
		check(r, 16'h8000);
		check({15'h0, en}, 16'h0001);
		foreach (rows[i])
		begin
			@(posedge clk);
			norm <= rows[i].n;
			wrrd(OFS_INDICATOR_OVERRIDE, rows[i].w, r);
			check({13'h0, ind}, {13'h0, rows[i].o});
			check(r, rows[i].r);
		end
		wr(OFS_PHY_FUNCTION_CONTROL, 16'hFFFF);
		check({13'h0, en, frc, swp}, 16'h0007);
		rd(OFS_PHY_FUNCTION_CONTROL, r);
		check(r, 16'hC000);
		wr(OFS_PHY_FUNCTION_CONTROL, 16'h0800);
		check({15'h0, inj}, 16'h0001);
		@(posedge clk);
		#1;
		check({15'h0, inj}, 16'h0000);
		rd(OFS_PHY_FUNCTION_CONTROL, r);
		check(r, 16'h0000);
		wr(5'h1A, 16'hFFFF);
		rd(5'h1A, r);
		check(r, 16'h0000);
		rd(OFS_INDICATOR_OVERRIDE, r);
		check(r, 16'h0007);
		for (int k = 0; k < 18; k++)
		begin
			c = 4'(k);
			@(posedge clk);
			anc <= (k != 17);
			afd <= (k < 16);
			ladv <= {4'h0, c[1:0], 10'h0};
			padv <= {4'h0, c[3:2], 10'h0};
			repeat (4) @(posedge clk);
			#1;
			erx = (c[0] & c[2]) | (c[0] & c[1] & !c[2] & c[3]);
			etx = (c[0] & c[2]) | (!c[0] & c[1] & c[2] & c[3]);
			if (k >= 16)
			begin
				erx = 1'b0;
				etx = 1'b0;
			end
			check({14'h0, prx, ptx}, {14'h0, erx, etx});
			rd(OFS_PHY_FUNCTION_CONTROL, r);
			check({14'h0, r[13:12]}, {14'h0, erx, etx});
		end
		wr(OFS_PHY_FUNCTION_CONTROL, 16'hC000);
		@(posedge clk);
		strap <= 1'b0;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check({11'h0, frc, swp, inj, prx, ptx}, 16'h0000);
		check({13'h0, ind}, {13'h0, norm});
		@(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_PHY_FUNCTION_CONTROL, r);
		check(r, 16'h0000);
		check({15'h0, en}, 16'h0000);
		report_and_stop;
	end
endmodule
